// ===== src/cfe_extractor.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module cfe_extractor
    import cfe_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic rx_valid,
    input wire logic rx_ide,
    input wire logic rx_rtr,
    input wire logic [28:0] rx_id,
    input wire logic [3:0] rx_dlc,
    input wire logic [63:0] rx_data,
    output logic [31:0] reg_rdata,
    output logic frame_hit,
    output logic extract_done,
    output logic [28:0] cfg_id
);

    cfe_state_t st_ff;
    cfe_state_t nxt_st;
    cfe_frame_t frm;
    cfe_req_t req;
    cfe_ext_id_t id_view;
    logic [28:0] want_id;
    logic id_ok;
    logic [3:0] nbytes;
    logic [6:0] q;
    logic start_ok;
    logic [63:0] le_in;
    logic [5:0] base;
    logic [32:0] mask;
    logic [63:0] shifted;

    assign frm = '{valid: rx_valid, ide: rx_ide, rtr: rx_rtr, id: rx_id, dlc: rx_dlc,
                   data: rx_data};
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // Result window decode, used by the read path only; writes there are ignored
    function automatic logic is_result(input logic [7:0] a);
        is_result = (a >= CFE_ADDR_RES_BASE) && (a <= CFE_ADDR_RES_LAST) && (a[1:0] == 2'b00);
    endfunction

    assign want_id = {st_ff.id_hi, st_ff.id_mid, st_ff.id_lo};
    // field view of the extended identifier
    assign id_view = cfe_ext_id_t'(want_id);

    // exact identifier match on data frames only
    // standard identifier when std_mode is set; the upper parameters are then unused
    always_comb begin
        if (st_ff.std_mode) begin
            id_ok = !frm.ide && (frm.id[10:0] == st_ff.id_lo);
        end else begin
            id_ok = frm.ide && (frm.id == {id_view.prio, id_view.reserved,
                    id_view.data_page, id_view.pdu_format, id_view.pdu_specific,
                    id_view.source_addr});
        end
    end

    // right-hand numbering counts from the last byte of the actual field
    // start bit locates the value's least significant bit
    assign nbytes = (frm.dlc > 4'h8) ? 4'h8 : frm.dlc;
    assign q = st_ff.start - 7'h01;
    assign start_ok = (st_ff.start != 7'h00) && ({1'b0, q[5:3]} < nbytes) &&
                      (st_ff.start <= 7'h40);
    assign base = {3'(nbytes - 4'h1 - {1'b0, q[5:3]}), q[2:0]};

    // byte 1 arrives first and sits in the top byte of rx_data
    // bytes reordered so byte 1 is least significant
    always_comb begin
        le_in = '0;
        for (int m = 0; m < CFE_FIELD_BYTES; m++) begin
            if (4'(m) < nbytes) begin
                le_in[8*m +: 8] = frm.data[63-8*m -: 8];
            end
        end
    end

    // value bits taken from lower to higher positions
    assign mask = (33'h000000001 << st_ff.nbits) - 33'h000000001;
    assign shifted = st_ff.le >> st_ff.pos[5:0];

    // Next-state logic for registers, status and the extraction engine
    always_comb begin
        nxt_st = st_ff;
        nxt_st.hit = 1'b0;
        nxt_st.fin = 1'b0;
        nxt_st.rdata = '0;
        // Read path: data appear in the next cycle only
        if (req.rd) begin
            if (req.addr == CFE_ADDR_ID_LO) begin
                nxt_st.rdata = 32'(st_ff.id_lo);
            end else if (req.addr == CFE_ADDR_ID_MID) begin
                nxt_st.rdata = 32'(st_ff.id_mid);
            end else if (req.addr == CFE_ADDR_ID_HI) begin
                nxt_st.rdata = 32'(st_ff.id_hi);
            end else if (req.addr == CFE_ADDR_CFG) begin
                nxt_st.rdata[CFE_CFG_STD_BIT] = st_ff.std_mode;
                nxt_st.rdata[CFE_CFG_TYPE_LSB +: 4] = st_ff.dtype;
                nxt_st.rdata[CFE_CFG_START_LSB +: 7] = st_ff.start;
                nxt_st.rdata[CFE_CFG_NBITS_LSB +: 6] = st_ff.nbits;
            end else if (req.addr == CFE_ADDR_COUNT) begin
                nxt_st.rdata = 32'(st_ff.nvals);
            end else if (req.addr == CFE_ADDR_STATUS) begin
                nxt_st.rdata[CFE_ST_DONE_BIT] = st_ff.done;
                nxt_st.rdata[CFE_ST_BADCFG_BIT] = st_ff.bad_cfg;
                nxt_st.rdata[CFE_ST_OVR_BIT] = st_ff.overrun;
                nxt_st.rdata[CFE_ST_BUSY_BIT] = (st_ff.fsm == CFE_EXTRACT);
                nxt_st.rdata[CFE_ST_CNT_LSB +: 8] = st_ff.match_cnt;
            end else if (is_result(req.addr)) begin
                nxt_st.rdata = st_ff.res[3'(req.addr[4:2])];
            end
        end
        // Write path; a status write clears the sticky flags
        if (req.wr) begin
            if (req.addr == CFE_ADDR_ID_LO) begin
                nxt_st.id_lo = req.wdata[10:0];
            end else if (req.addr == CFE_ADDR_ID_MID) begin
                nxt_st.id_mid = req.wdata[12:0];
            end else if (req.addr == CFE_ADDR_ID_HI) begin
                nxt_st.id_hi = req.wdata[4:0];
            end else if (req.addr == CFE_ADDR_CFG) begin
                nxt_st.std_mode = req.wdata[CFE_CFG_STD_BIT];
                nxt_st.dtype = req.wdata[CFE_CFG_TYPE_LSB +: 4];
                nxt_st.start = req.wdata[CFE_CFG_START_LSB +: 7];
                nxt_st.nbits = req.wdata[CFE_CFG_NBITS_LSB +: 6];
            end else if (req.addr == CFE_ADDR_COUNT) begin
                nxt_st.nvals = req.wdata[3:0];
            end else if (req.addr == CFE_ADDR_STATUS) begin
                nxt_st.done = 1'b0;
                nxt_st.bad_cfg = 1'b0;
                nxt_st.overrun = 1'b0;
            end
        end
        // Extraction engine; its flag sets come after the clears so a set wins
        case (st_ff.fsm)
            CFE_IDLE: begin
                if (frm.valid && !frm.rtr && id_ok) begin
                    nxt_st.hit = 1'b1;
                    nxt_st.match_cnt = st_ff.match_cnt + 8'h01;
                    if (start_ok && (st_ff.dtype == CFE_TYPE_UINT_LSB) &&
                        (st_ff.nbits != 6'h00) && (st_ff.nbits <= 6'h20) &&
                        (st_ff.nvals != 4'h0) && (st_ff.nvals <= 4'(CFE_MAX_VALUES))) begin
                        nxt_st.le = le_in;
                        nxt_st.pos = {1'b0, base};
                        nxt_st.vidx = 3'h0;
                        nxt_st.fsm = CFE_EXTRACT;
                    end else begin
                        nxt_st.bad_cfg = 1'b1;
                    end
                end
            end
            CFE_EXTRACT: begin
                // one value per cycle into consecutive slots
                nxt_st.res[st_ff.vidx] = shifted[31:0] & mask[31:0];
                nxt_st.vidx = st_ff.vidx + 3'h1;
                nxt_st.pos = st_ff.pos - {1'b0, st_ff.nbits};
                // A frame arriving mid-extraction is dropped, not queued
                if (frm.valid) begin
                    nxt_st.overrun = 1'b1;
                end
                // Stop on the last value or when the next one would run off the field
                if ((4'(st_ff.vidx) + 4'h1 >= st_ff.nvals) ||
                    (st_ff.pos < {1'b0, st_ff.nbits})) begin
                    nxt_st.fsm = CFE_IDLE;
                    nxt_st.done = 1'b1;
                    nxt_st.fin = 1'b1;
                end
            end
            default: begin
                nxt_st.fsm = CFE_IDLE;
            end
        endcase
    end

    // State register with constant reset values
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.id_lo <= CFE_RST_ID_LO;
            st_ff.id_mid <= CFE_RST_ID_MID;
            st_ff.id_hi <= CFE_RST_ID_HI;
            st_ff.dtype <= CFE_RST_TYPE;
            st_ff.start <= CFE_RST_START;
            st_ff.nbits <= CFE_RST_NBITS;
            st_ff.nvals <= CFE_RST_NVALS;
            st_ff.fsm <= CFE_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = st_ff.rdata;
    assign frame_hit = st_ff.hit;
    assign extract_done = st_ff.fin;
    assign cfg_id = want_id;

    // Identifier mapping checks
    chk_id_lo_map: assert property (@(posedge clock) disable iff (!rstn)
        req.wr && req.addr == CFE_ADDR_ID_LO |=> cfg_id[10:0] == $past(req.wdata[10:0]))
        else $error("id low bits misplaced");
    chk_id_mid_map: assert property (@(posedge clock) disable iff (!rstn)
        req.wr && req.addr == CFE_ADDR_ID_MID |=> cfg_id[23:11] == $past(req.wdata[12:0]))
        else $error("id middle bits misplaced");
    chk_id_hi_map: assert property (@(posedge clock) disable iff (!rstn)
        req.wr && req.addr == CFE_ADDR_ID_HI |=> cfg_id[28:24] == $past(req.wdata[4:0]))
        else $error("id high bits misplaced");
    chk_prio_field: assert property (@(posedge clock) disable iff (!rstn)
        id_view.prio == st_ff.id_hi[4:2] && id_view.data_page == st_ff.id_hi[0])
        else $error("priority or page field misplaced");

    // Frame acceptance checks; a frame while busy is dropped rather than queued,
    // so the block never needs a frame buffer
    chk_std_reject: assert property (@(posedge clock) disable iff (!rstn)
        st_ff.std_mode && frm.valid && frm.ide |=> !frame_hit)
        else $error("extended frame hit in standard mode");
    chk_rtr_ignored: assert property (@(posedge clock) disable iff (!rstn)
        frm.valid && frm.rtr |=> !frame_hit) else $error("remote frame hit");
    chk_busy_drop: assert property (@(posedge clock) disable iff (!rstn)
        st_ff.fsm == CFE_EXTRACT && frm.valid |=> !frame_hit)
        else $error("frame during extraction not dropped");
    chk_overrun_set: assert property (@(posedge clock) disable iff (!rstn)
        st_ff.fsm == CFE_EXTRACT && frm.valid |=> st_ff.overrun)
        else $error("overrun flag not set");
    chk_bad_type: assert property (@(posedge clock) disable iff (!rstn)
        st_ff.fsm == CFE_IDLE && frm.valid && !frm.rtr && id_ok &&
        st_ff.dtype != CFE_TYPE_UINT_LSB |=> st_ff.bad_cfg && st_ff.fsm == CFE_IDLE)
        else $error("unsupported type code decoded");
    chk_bad_start: assert property (@(posedge clock) disable iff (!rstn)
        st_ff.fsm == CFE_IDLE && frm.valid && !frm.rtr && id_ok && !start_ok |=>
        st_ff.bad_cfg && st_ff.fsm == CFE_IDLE) else $error("start outside field decoded");
    chk_std_match: assert property (@(posedge clock) disable iff (!rstn)
        st_ff.fsm == CFE_IDLE && st_ff.std_mode && frm.valid && !frm.rtr && !frm.ide &&
        frm.id[10:0] == st_ff.id_lo |=> frame_hit) else $error("standard id missed");
    chk_no_false_hit: assert property (@(posedge clock) disable iff (!rstn)
        frame_hit |-> $past(frm.valid) && !$past(frm.rtr) && $past(id_ok))
        else $error("hit without matching data frame");
    chk_ext_exact: assert property (@(posedge clock) disable iff (!rstn)
        !st_ff.std_mode && frm.valid && frm.ide && id_ok |-> frm.id == cfg_id)
        else $error("extended id not exact");

    // Extraction checks; nbits must not be rewritten mid-run or these may misfire
    chk_first_lsb: assert property (@(posedge clock) disable iff (!rstn)
        $rose(st_ff.fsm == CFE_EXTRACT) |-> st_ff.vidx == 3'h0 ##1
        st_ff.res[0] == ($past(shifted[31:0]) & $past(mask[31:0])))
        else $error("first value not from start bit");
    chk_byte_order: assert property (@(posedge clock) disable iff (!rstn)
        frm.valid && nbytes != 4'h0 |-> le_in[7:0] == frm.data[63:56])
        else $error("byte one not least significant");
    chk_done_bound: assert property (@(posedge clock) disable iff (!rstn)
        $rose(st_ff.fsm == CFE_EXTRACT) |-> ##[1:8] extract_done)
        else $error("extraction did not finish");
    chk_done_sticky: assert property (@(posedge clock) disable iff (!rstn)
        extract_done |-> st_ff.done) else $error("done flag not set");
    chk_done_pulse: assert property (@(posedge clock) disable iff (!rstn)
        extract_done |=> !extract_done) else $error("done pulse longer than one cycle");

    // Value shape and numbering checks
    chk_value_width: assert property (@(posedge clock) disable iff (!rstn)
        st_ff.fsm == CFE_EXTRACT |=>
        (st_ff.res[$past(st_ff.vidx)] >> $past(st_ff.nbits)) == 32'h0)
        else $error("value wider than its bit count");
    chk_rh_numbering: assert property (@(posedge clock) disable iff (!rstn)
        nbytes == 4'h8 && (st_ff.start == 7'h01 || st_ff.start == 7'h40) |->
        base == ((st_ff.start == 7'h01) ? 6'h38 : 6'h07))
        else $error("right-hand bit numbering wrong");
    chk_wire_order: assert property (@(posedge clock) disable iff (!rstn)
        frm.valid && nbytes == 4'h8 |-> le_in[63:56] == frm.data[7:0])
        else $error("last byte not most significant");

    // Main scenarios: both id modes, multi-value runs, overrun, bad configuration
    cov_ext_hit: cover property (@(posedge clock) disable iff (!rstn)
        frame_hit && !st_ff.std_mode);
    cov_std_hit: cover property (@(posedge clock) disable iff (!rstn)
        frame_hit && st_ff.std_mode);
    cov_multi: cover property (@(posedge clock) disable iff (!rstn)
        extract_done && st_ff.vidx > 3'h1);
    cov_overrun: cover property (@(posedge clock) disable iff (!rstn) $rose(st_ff.overrun));
    cov_bad_cfg: cover property (@(posedge clock) disable iff (!rstn) $rose(st_ff.bad_cfg));

endmodule

// ===== src/cfe_pkg.sv
package cfe_pkg;

    // Register word addresses (byte addresses, one aligned word each)
    localparam logic [7:0] CFE_ADDR_ID_LO = 8'h00;
    localparam logic [7:0] CFE_ADDR_ID_MID = 8'h04;
    localparam logic [7:0] CFE_ADDR_ID_HI = 8'h08;
    localparam logic [7:0] CFE_ADDR_CFG = 8'h0C;
    localparam logic [7:0] CFE_ADDR_COUNT = 8'h10;
    localparam logic [7:0] CFE_ADDR_STATUS = 8'h14;
    localparam logic [7:0] CFE_ADDR_RES_BASE = 8'h20;
    localparam logic [7:0] CFE_ADDR_RES_LAST = 8'h3C;

    // Identifier parameter split widths
    localparam int CFE_ID_LO_W = 11;
    localparam int CFE_ID_MID_W = 13;
    localparam int CFE_ID_HI_W = 5;

    // Configuration and status field positions
    localparam int CFE_CFG_STD_BIT = 0;
    localparam int CFE_CFG_TYPE_LSB = 8;
    localparam int CFE_CFG_START_LSB = 16;
    localparam int CFE_CFG_NBITS_LSB = 24;
    localparam int CFE_ST_DONE_BIT = 0;
    localparam int CFE_ST_BADCFG_BIT = 1;
    localparam int CFE_ST_OVR_BIT = 2;
    localparam int CFE_ST_BUSY_BIT = 3;
    localparam int CFE_ST_CNT_LSB = 8;

    // Data type code for unsigned integers, least significant byte first
    localparam logic [3:0] CFE_TYPE_UINT_LSB = 4'h2;
    localparam int CFE_MAX_VALUES = 8;
    localparam int CFE_FIELD_BYTES = 8;

    // Reset values
    localparam logic [10:0] CFE_RST_ID_LO = 11'h000;
    localparam logic [12:0] CFE_RST_ID_MID = 13'h0000;
    localparam logic [4:0] CFE_RST_ID_HI = 5'h00;
    localparam logic [3:0] CFE_RST_TYPE = 4'h2;
    localparam logic [6:0] CFE_RST_START = 7'h01;
    localparam logic [5:0] CFE_RST_NBITS = 6'h08;
    localparam logic [3:0] CFE_RST_NVALS = 4'h1;

    // Extended identifier field layout, bit 28 down to bit 0
    typedef struct packed {
        logic [2:0] prio;
        logic reserved;
        logic data_page;
        logic [7:0] pdu_format;
        logic [7:0] pdu_specific;
        logic [7:0] source_addr;
    } cfe_ext_id_t;

    // Received frame as delivered by the bit-level receiver
    typedef struct packed {
        logic valid;
        logic ide;
        logic rtr;
        logic [28:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } cfe_frame_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } cfe_req_t;

    typedef enum logic [0:0] {
        CFE_IDLE,
        CFE_EXTRACT
    } cfe_fsm_t;

    typedef struct packed {
        logic [10:0] id_lo;
        logic [12:0] id_mid;
        logic [4:0] id_hi;
        logic std_mode;
        logic [3:0] dtype;
        logic [6:0] start;
        logic [5:0] nbits;
        logic [3:0] nvals;
        logic done;
        logic bad_cfg;
        logic overrun;
        logic [7:0] match_cnt;
        cfe_fsm_t fsm;
        logic [63:0] le;
        logic [6:0] pos;
        logic [2:0] vidx;
        logic [7:0][31:0] res;
        logic [31:0] rdata;
        logic hit;
        logic fin;
    } cfe_state_t;

endpackage

// ===== sim/cfe_can_node.sv
`timescale 1ns/1ps
// Far-side node: presents one received frame in each cycle that tx.valid is high
module cfe_can_node
    import cfe_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire cfe_frame_t tx,
    output cfe_frame_t rx
);
    cfe_frame_t last_ff;
    // Remember the last frame so idle lines can show its inverse
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            last_ff <= '0;
        end else if (tx.valid) begin
            last_ff <= tx;
        end
    end
    // byte one leads
    // Byte 1 MSB sits in data[63]; idle lines carry junk so stale data cannot pass
    always_comb begin
        rx = tx.valid ? tx : ~last_ff;
        rx.valid = tx.valid;
    end
endmodule

// ===== sim/can_field_extractor_j1939_id_tb.sv
`timescale 1ns/1ps
module can_field_extractor_j1939_id_tb
    import cfe_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    cfe_frame_t fr = '0;
    cfe_frame_t rx;
    cfe_frame_t f;
    cfe_ext_id_t e;
    logic [31:0] reg_rdata;
    logic frame_hit;
    logic extract_done;
    logic [28:0] cfg_id;
    logic [31:0] rq[$];
    int bad_count = 0;
    int checks_done = 0;
    int hits = 0;
    int nb, nv, pos, zq, st;

    // Half period of the 40 MHz clock
    always #12.5 clock = ~clock;

    cfe_can_node u_node (.clock(clock), .rstn(rstn), .tx(fr), .rx(rx));

    cfe_extractor u_dut (
        .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .rx_valid(rx.valid), .rx_ide(rx.ide),
        .rx_rtr(rx.rtr), .rx_id(rx.id), .rx_dlc(rx.dlc), .rx_data(rx.data),
        .reg_rdata(reg_rdata), .frame_hit(frame_hit), .extract_done(extract_done),
        .cfg_id(cfg_id)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data are noted now and compared by the watcher one cycle later
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rq.push_back(exp);
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask

    // Hold keeps valid up one more cycle so the second copy meets a busy block
    task automatic send(input cfe_frame_t x, input logic hit, input int n, input int hold);
        @(posedge clock);
        fr <= x;
        @(posedge clock);
        if (hold == 0) fr.valid <= 1'b0;
        #1 chk(32'(frame_hit), 32'(hit));
        if (hit) hits++;
        if (hold != 0) begin
            @(posedge clock);
            fr.valid <= 1'b0;
        end
        repeat ((n == 0) ? 1 : n - hold) @(posedge clock);
        #1 chk(32'(extract_done), 32'(n != 0));
    endtask

    function automatic logic [31:0] ext_val(input logic [63:0] d, input int p, input int w,
        input int v);
        logic [63:0] le;
        for (int k = 0; k < 8; k++) le[8*k +: 8] = d[63-8*k -: 8];
        return 32'((le >> (p - v * w)) & ((64'h1 << w) - 64'h1));
    endfunction

    // Watcher: reg_rdata stands only in the cycle after the read strobe
    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (rd_d) chk(reg_rdata, rq.pop_front());
    end

    // Watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hde8d60f8));
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        // Reset values, unmapped and read-only places
        rd(CFE_ADDR_CFG, 32'h08010200);
        rd(CFE_ADDR_COUNT, 32'h1);
        rd(CFE_ADDR_STATUS, 32'h0);
        rd(8'h18, 32'h0);
        wr(CFE_ADDR_RES_BASE, $urandom);
        rd(CFE_ADDR_RES_BASE, 32'h0);
        // Identifier from priority 3, format 240, specific 3: parameters 768, 7680, 12
        e = '{prio: 3'h3, reserved: 1'b0, data_page: 1'b0, pdu_format: 8'hF0,
              pdu_specific: 8'h03, source_addr: 8'h00};
        wr(CFE_ADDR_ID_LO, 32'h300);
        wr(CFE_ADDR_ID_MID, 32'h1E00);
        wr(CFE_ADDR_ID_HI, 32'h0C);
        rd(CFE_ADDR_ID_MID, 32'h1E00);
        #1 chk({3'h0, cfg_id}, {3'h0, e});
        // Start 49, eight bits: the value is byte 2
        wr(CFE_ADDR_CFG, 32'h08310200);
        rd(CFE_ADDR_CFG, 32'h08310200);
        f = '{valid: 1'b1, ide: 1'b1, rtr: 1'b0, id: e, dlc: 4'h8, data: {$urandom, $urandom}};
        send(f, 1'b1, 1, 0);
        rd(CFE_ADDR_RES_BASE, {24'h0, f.data[55:48]});
        // Random fields, widths and counts, each inside the 64-bit field
        for (int it = 0; it < 16; it++) begin
            nb = 1 + $urandom % 16;
            nv = 1 + $urandom % ((64 / nb > 4) ? 4 : 64 / nb);
            pos = (nv - 1) * nb + $urandom % (65 - nv * nb);
            zq = 8 * (7 - pos / 8) + pos % 8;
            st = zq + 1;
            wr(CFE_ADDR_CFG, {2'h0, 6'(nb), 1'b0, 7'(st), 4'h0, CFE_TYPE_UINT_LSB, 8'h00});
            wr(CFE_ADDR_COUNT, 32'(nv));
            f.data = {$urandom, $urandom};
            send(f, 1'b1, nv, 0);
            for (int v = 0; v < nv; v++) begin
                rd(CFE_ADDR_RES_BASE + 8'(4 * v), ext_val(f.data, pos, nb, v));
            end
        end
        // Near misses: one identifier bit off, standard frame, remote frame
        for (int c = 0; c < 3; c++) begin
            f = '{valid: 1'b1, ide: (c != 1), rtr: (c == 2), id: e, dlc: 4'h8, data: '0};
            if (c == 0) f.id[$urandom % 29] ^= 1'b1;
            send(f, 1'b0, 0, 0);
        end
        // Standard mode matches bits 10..0 only, and only on standard frames
        wr(CFE_ADDR_COUNT, 32'h1);
        wr(CFE_ADDR_CFG, 32'h08310201);
        f = '{valid: 1'b1, ide: 1'b0, rtr: 1'b0, id: {18'($urandom), 11'h300}, dlc: 4'h8,
              data: {$urandom, $urandom}};
        send(f, 1'b1, 1, 0);
        rd(CFE_ADDR_RES_BASE, {24'h0, f.data[55:48]});
        f.ide = 1'b1;
        send(f, 1'b0, 0, 0);
        // Unsupported type code: hit and count, but no extraction
        wr(CFE_ADDR_STATUS, 32'h0);
        wr(CFE_ADDR_CFG, 32'h08310300);
        f = '{valid: 1'b1, ide: 1'b1, rtr: 1'b0, id: e, dlc: 4'h8, data: '0};
        send(f, 1'b1, 0, 0);
        rd(CFE_ADDR_STATUS, 32'h2 | 32'((hits % 256) << 8));
        // Three bytes from start 1 (bytes 8, 7, 6); a second frame while busy overruns
        wr(CFE_ADDR_STATUS, 32'h0);
        wr(CFE_ADDR_CFG, 32'h08010200);
        wr(CFE_ADDR_COUNT, 32'h3);
        f.data = {$urandom, $urandom};
        send(f, 1'b1, 3, 1);
        for (int v = 0; v < 3; v++) begin
            rd(CFE_ADDR_RES_BASE + 8'(4 * v), ext_val(f.data, 56, 8, v));
        end
        rd(CFE_ADDR_STATUS, 32'h5 | 32'((hits % 256) << 8));
        // Three-byte field, two 12-bit values from start 13; unused low bytes are junk
        wr(CFE_ADDR_CFG, 32'h0C0D0200);
        wr(CFE_ADDR_COUNT, 32'h2);
        f.dlc = 4'h3;
        f.data = {$urandom, $urandom};
        send(f, 1'b1, 2, 0);
        rd(CFE_ADDR_RES_BASE, {20'h0, f.data[47:40], f.data[55:52]});
        rd(CFE_ADDR_RES_BASE + 8'h04, {20'h0, f.data[51:48], f.data[63:56]});
        // Start byte beyond a two-byte field: hit and count, no extraction
        wr(CFE_ADDR_STATUS, 32'h0);
        wr(CFE_ADDR_CFG, 32'h10110200);
        f.dlc = 4'h2;
        send(f, 1'b1, 0, 0);
        rd(CFE_ADDR_STATUS, 32'h2 | 32'((hits % 256) << 8));
        // Two-byte field, one 16-bit value from start 9: byte 1 is the low byte
        wr(CFE_ADDR_CFG, 32'h10090200);
        wr(CFE_ADDR_COUNT, 32'h1);
        send(f, 1'b1, 1, 0);
        rd(CFE_ADDR_RES_BASE, {16'h0, f.data[55:48], f.data[63:56]});
        repeat (3) @(posedge clock);
        tally_and_finish();
    end
endmodule
